// ---- common/tcsr_pkg.sv ----
// Purpose: constants and types of the timer control and sync registers
// Assumes: one 10 MHz clock, kernel tick is an enable pulse
// Notes: register offsets are byte offsets on the plain register port
// How it works
// RQ1 - Enable reads back now, busy until applied
// RQ2 - Soft reset clears all but debug, disables
// RQ3 - Soft reset write discards its other fields
// RQ4 - Soft reset bit and busy clear together
// RQ5 - Enable and soft reset writable while enabled
// RQ6 - Read request syncs addressed register, sets busy
// RQ7 - Read request bit reads zero, zero ignored
// RQ8 - Continuous read resyncs on every change
// RQ9 - Address field picks counter or compare registers
// RQ10 - Clear and set aliases show one register
// RQ11 - Command runs next kernel tick, then zero
// RQ12 - Command codes none, retrigger, stop, reserved
// RQ13 - Clear alias command ones cancel pending
// RQ14 - Set alias nonzero command becomes pending
// RQ15 - Single run stops after next wrap
// RQ16 - Clear alias one turns single run off
// RQ17 - Clear alias one clears direction
// RQ18 - Direction zero counts up, one down
// RQ19 - Set alias one turns single run on
// RQ20 - Set alias one sets direction down
// RQ21 - Stop holds count until retrigger or start
// RQ22 - Visible value stable while sync busy
package tcsr_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_PRIMARY = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_READ_REQ = 5'h02;
  localparam logic [ADDR_W-1:0] OFS_CB_CLR = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CB_SET = 5'h05;
  localparam logic [ADDR_W-1:0] OFS_DEBUG = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h0f;
  localparam logic [ADDR_W-1:0] OFS_COUNT = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_CC0 = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_CC1 = 5'h1a;

  // Field positions
  localparam int PC_SOFT_RESET_BIT = 0;
  localparam int PC_ENABLE = 1;
  localparam int RR_READ_REQUEST_BIT = 15;
  localparam int RR_CONTINUOUS_READ_BIT = 14;
  localparam int CB_DIR = 0;
  localparam int CB_SINGLE_RUN_BIT = 2;
  localparam int CB_CMD_LSB = 6;
  localparam int SB_SOFT_RESET_BIT = 0;
  localparam int SB_ENABLE = 1;
  localparam int SB_READ = 2;
  localparam int DBG_RUN = 0;

  // Values
  localparam logic [DATA_W-1:0] ZERO16 = 16'h0000;
  localparam logic [DATA_W-1:0] COUNT_MAX = 16'hffff;
  localparam logic [DATA_W-1:0] ONE16 = 16'h0001;

  // Kernel tick period derived from the system clock
  localparam int SYS_CLK_NS = 100;
  localparam int KERNEL_PERIOD_NS = 400;
  localparam logic [2:0] KDIV_LAST = 3'(KERNEL_PERIOD_NS / SYS_CLK_NS - 1);

  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_RETRIG = 2'h1,
    CMD_STOP = 2'h2,
    CMD_RSVD = 2'h3
  } tcsr_cmd_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic we;
    logic re;
  } tcsr_req_t;
endpackage

// ---- hdl/tcsr_top.sv ----
// Purpose: control, soft reset and read sync registers of a timer
// Assumes: single clock, kernel domain runs on a divided enable tick
// Notes: start event pin is synchronised before use
//
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module tcsr_top import tcsr_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic nrst_i,
  input wire tcsr_req_t req_i,
  input wire logic start_evt_i,
  output logic [DATA_W-1:0] rdata_o,
  output logic [DATA_W-1:0] count_o,
  output logic running_o,
  output logic active_o,
  output logic dir_o,
  output logic one_shot_o
);
  // Address match used by every register decode
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    hit = (a == ofs);
  endfunction

  logic [2:0] div_cnt;
  logic tick;
  logic enable;
  logic soft_reset_bit;
  logic busy_en;
  logic active;
  logic continuous_read_bit;
  logic [ADDR_W-1:0] raddr;
  logic busy_rd;
  logic [DATA_W-1:0] rsnap;
  logic [DATA_W-1:0] sel_val;
  tcsr_cmd_t cmd;
  tcsr_cmd_t wcmd;
  logic single_run_bit;
  logic dir;
  logic dbg_run;
  logic [DATA_W-1:0] count;
  logic [DATA_W-1:0] cc0;
  logic [DATA_W-1:0] cc1;
  logic running;
  logic evt_s1;
  logic evt_s2;
  logic evt_s3;
  logic evt_pend;
  logic soft_reset_bit_done;
  logic wrap;
  logic wr_pc;
  logic wr_rr;
  logic wr_clr;
  logic wr_set;
  logic [DATA_W-1:0] next_rdata;

  // Write decodes
  assign wr_pc = req_i.we && hit(req_i.addr, OFS_PRIMARY);
  assign wr_rr = req_i.we && hit(req_i.addr, OFS_READ_REQ);
  assign wr_clr = req_i.we && hit(req_i.addr, OFS_CB_CLR);
  assign wr_set = req_i.we && hit(req_i.addr, OFS_CB_SET);
  assign wcmd = tcsr_cmd_t'(req_i.wdata[CB_CMD_LSB +: 2]);
  assign soft_reset_bit_done = tick && soft_reset_bit;
  assign wrap = dir ? (count == ZERO16) : (count == COUNT_MAX);

  // Kernel tick divider
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_cnt <= 3'h0;
      tick <= 1'b0;
    end else if (div_cnt == KDIV_LAST) begin
      div_cnt <= 3'h0;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 3'h1;
      tick <= 1'b0;
    end
  end

  // Primary control: enable, soft reset, enable busy
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enable <= 1'b0;
      soft_reset_bit <= 1'b0;
      busy_en <= 1'b0;
    end else if (soft_reset_bit_done) begin
      enable <= 1'b0; // RQ2
      soft_reset_bit <= 1'b0; // RQ4
      busy_en <= 1'b0;
    end else if (wr_pc && !soft_reset_bit) begin
      if (req_i.wdata[PC_SOFT_RESET_BIT]) begin
        soft_reset_bit <= 1'b1; // RQ3 RQ5
      end else begin
        enable <= req_i.wdata[PC_ENABLE]; // RQ1 RQ5
        busy_en <= 1'b1; // RQ1
      end
    end else if (busy_en && tick) begin
      busy_en <= 1'b0; // RQ1
    end
  end

  // Kernel side enable follows software enable on each tick
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      active <= 1'b0;
    end else if (tick) begin
      active <= soft_reset_bit ? 1'b0 : enable; // RQ1 RQ2
    end
  end

  // Debug control survives soft reset
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dbg_run <= 1'b0;
    end else if (req_i.we && hit(req_i.addr, OFS_DEBUG)) begin
      dbg_run <= req_i.wdata[DBG_RUN]; // RQ2
    end
  end

  // Value of the register picked for read sync
  always_comb begin
    if (hit(raddr, OFS_COUNT)) begin
      sel_val = count; // RQ9
    end else if (hit(raddr, OFS_CC0)) begin
      sel_val = cc0;
    end else if (hit(raddr, OFS_CC1)) begin
      sel_val = cc1;
    end else begin
      sel_val = ZERO16;
    end
  end

  // Read request register and sync busy
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      continuous_read_bit <= 1'b0;
      raddr <= 5'h00;
      busy_rd <= 1'b0;
    end else if (soft_reset_bit_done) begin
      continuous_read_bit <= 1'b0; // RQ2
      raddr <= 5'h00;
      busy_rd <= 1'b0;
    end else begin
      if (tick) begin
        busy_rd <= 1'b0;
      end
      if (wr_rr && !soft_reset_bit) begin
        continuous_read_bit <= req_i.wdata[RR_CONTINUOUS_READ_BIT]; // RQ8
        raddr <= req_i.wdata[ADDR_W-1:0]; // RQ9
        if (req_i.wdata[RR_READ_REQUEST_BIT]) begin
          busy_rd <= 1'b1; // RQ6 RQ7
        end
      end
    end
  end

  // Snapshot moves only on a kernel tick
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rsnap <= ZERO16;
    end else if (soft_reset_bit_done) begin
      rsnap <= ZERO16;
    end else if (tick && (busy_rd || (continuous_read_bit && sel_val != rsnap))) begin
      rsnap <= sel_val; // RQ6 RQ8 RQ22
    end
  end

  // Secondary control through both aliases
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmd <= CMD_NONE;
      single_run_bit <= 1'b0;
      dir <= 1'b0;
    end else if (soft_reset_bit_done) begin
      cmd <= CMD_NONE; // RQ2
      single_run_bit <= 1'b0;
      dir <= 1'b0;
    end else begin
      if (tick && active && cmd != CMD_NONE) begin
        cmd <= CMD_NONE; // RQ11
      end
      if (wr_clr && !soft_reset_bit) begin
        if (wcmd != CMD_NONE) begin
          cmd <= CMD_NONE; // RQ13
        end
        if (req_i.wdata[CB_SINGLE_RUN_BIT]) begin
          single_run_bit <= 1'b0; // RQ16
        end
        if (req_i.wdata[CB_DIR]) begin
          dir <= 1'b0; // RQ17
        end
      end
      if (wr_set && !soft_reset_bit) begin
        if (wcmd != CMD_NONE) begin
          cmd <= wcmd; // RQ12 RQ14
        end
        if (req_i.wdata[CB_SINGLE_RUN_BIT]) begin
          single_run_bit <= 1'b1; // RQ19
        end
        if (req_i.wdata[CB_DIR]) begin
          dir <= 1'b1; // RQ20
        end
      end
    end
  end

  // Start event pin synchroniser and edge
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_s1 <= 1'b0;
      evt_s2 <= 1'b0;
      evt_s3 <= 1'b0;
    end else begin
      evt_s1 <= start_evt_i;
      evt_s2 <= evt_s1;
      evt_s3 <= evt_s2;
    end
  end

  // Start event held until the next tick, new edge wins
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      evt_pend <= 1'b0;
    end else if (evt_s2 && !evt_s3) begin
      evt_pend <= 1'b1;
    end else if (tick) begin
      evt_pend <= 1'b0;
    end
  end

  // Compare registers written directly
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cc0 <= ZERO16;
      cc1 <= ZERO16;
    end else if (soft_reset_bit_done) begin
      cc0 <= ZERO16; // RQ2
      cc1 <= ZERO16;
    end else if (req_i.we && !soft_reset_bit) begin
      if (hit(req_i.addr, OFS_CC0)) begin
        cc0 <= req_i.wdata;
      end
      if (hit(req_i.addr, OFS_CC1)) begin
        cc1 <= req_i.wdata;
      end
    end
  end

  // Counter on the kernel tick
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      count <= ZERO16;
      running <= 1'b1;
    end else if (soft_reset_bit_done) begin
      count <= ZERO16; // RQ2
      running <= 1'b1;
    end else if (tick && active) begin
      if (cmd == CMD_RETRIG) begin
        count <= dir ? COUNT_MAX : ZERO16; // RQ12
        running <= 1'b1; // RQ21
      end else if (cmd == CMD_STOP) begin
        running <= 1'b0; // RQ21
      end else if (!running) begin
        running <= evt_pend; // RQ21
      end else if (wrap) begin
        count <= dir ? COUNT_MAX : ZERO16; // RQ15
        running <= !single_run_bit; // RQ15
      end else if (dir) begin
        count <= count - ONE16; // RQ18
      end else begin
        count <= count + ONE16; // RQ18
      end
    end
  end

  // Read mux, both aliases show the same bits
  always_comb begin
    next_rdata = ZERO16;
    if (req_i.re) begin
      if (hit(req_i.addr, OFS_PRIMARY)) begin
        next_rdata[PC_ENABLE] = enable; // RQ1
        next_rdata[PC_SOFT_RESET_BIT] = soft_reset_bit; // RQ4
      end else if (hit(req_i.addr, OFS_READ_REQ)) begin
        next_rdata[RR_CONTINUOUS_READ_BIT] = continuous_read_bit; // RQ7
        next_rdata[ADDR_W-1:0] = raddr;
      end else if (hit(req_i.addr, OFS_CB_CLR) || hit(req_i.addr, OFS_CB_SET)) begin
        next_rdata[CB_CMD_LSB +: 2] = cmd; // RQ10
        next_rdata[CB_SINGLE_RUN_BIT] = single_run_bit;
        next_rdata[CB_DIR] = dir;
      end else if (hit(req_i.addr, OFS_DEBUG)) begin
        next_rdata[DBG_RUN] = dbg_run;
      end else if (hit(req_i.addr, OFS_STATUS)) begin
        next_rdata[SB_SOFT_RESET_BIT] = soft_reset_bit; // RQ4
        next_rdata[SB_ENABLE] = busy_en;
        next_rdata[SB_READ] = busy_rd; // RQ6
      end else if (hit(req_i.addr, OFS_COUNT)) begin
        next_rdata = hit(raddr, OFS_COUNT) ? rsnap : count; // RQ22
      end else if (hit(req_i.addr, OFS_CC0)) begin
        next_rdata = hit(raddr, OFS_CC0) ? rsnap : cc0;
      end else if (hit(req_i.addr, OFS_CC1)) begin
        next_rdata = hit(raddr, OFS_CC1) ? rsnap : cc1;
      end
    end
  end

  // Registered outputs
  always_ff @(posedge sys_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_o <= ZERO16;
      count_o <= ZERO16;
      running_o <= 1'b0;
      active_o <= 1'b0;
      dir_o <= 1'b0;
      one_shot_o <= 1'b0;
    end else begin
      rdata_o <= next_rdata;
      count_o <= count;
      running_o <= running;
      active_o <= active;
      dir_o <= dir;
      one_shot_o <= single_run_bit;
    end
  end

  // Checks
  a_en_write_busy: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ1
    wr_pc && !soft_reset_bit && !req_i.wdata[PC_SOFT_RESET_BIT] |=> busy_en && enable == $past(req_i.wdata[PC_ENABLE]))
    else $error("enable write not taken");
  a_en_busy_done: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ1
    $fell(busy_en) && !$past(soft_reset_bit) |-> active == enable)
    else $error("enable busy cleared early");
  a_soft_reset_bit_prio: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ3
    wr_pc && !soft_reset_bit && req_i.wdata[PC_SOFT_RESET_BIT] |=> soft_reset_bit && enable == $past(enable) && busy_en == $past(busy_en))
    else $error("soft reset write not exclusive");
  a_soft_reset_bit_end: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ4
    $rose(soft_reset_bit) |-> ##[1:4] !soft_reset_bit)
    else $error("soft reset never completes");
  a_soft_reset_bit_clear: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ2
    $fell(soft_reset_bit) |-> !enable && !active && cmd == CMD_NONE && !single_run_bit && !dir)
    else $error("soft reset left state");
  a_read_request_bit_busy: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ6
    wr_rr && !soft_reset_bit && req_i.wdata[RR_READ_REQUEST_BIT] |=> busy_rd ##[1:4] !busy_rd)
    else $error("read request busy wrong");
  a_read_request_bit_zero: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ7
    req_i.re && hit(req_i.addr, OFS_READ_REQ) |=> !rdata_o[RR_READ_REQUEST_BIT])
    else $error("read request bit read one");
  a_snap_stable: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ22
    busy_rd && !tick && !soft_reset_bit |=> $stable(rsnap))
    else $error("snapshot moved while busy");
  a_cmd_stop: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ11
    tick && active && !soft_reset_bit && cmd == CMD_STOP && !wr_set |=> !running && cmd == CMD_NONE)
    else $error("stop command not executed");
  a_clr_cancel: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ13
    wr_clr && !soft_reset_bit && wcmd != CMD_NONE |=> cmd == CMD_NONE)
    else $error("clear alias did not cancel");
  a_count_down: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ18
    tick && active && running && !soft_reset_bit && cmd == CMD_NONE && dir && count != ZERO16
    |=> count == $past(count) - ONE16)
    else $error("down count wrong");
  a_single_run_bit_stop: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ15
    tick && active && running && !soft_reset_bit && cmd == CMD_NONE && single_run_bit && wrap |=> !running)
    else $error("single run did not stop");
  // Alias and command checks
  a_set_pending: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ14
    wr_set && !soft_reset_bit && wcmd != CMD_NONE |=> cmd == $past(wcmd))
    else $error("set alias command not pending");
  a_retrig_load: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ12
    tick && active && !soft_reset_bit && cmd == CMD_RETRIG |=> running && count == ($past(dir) ? COUNT_MAX : ZERO16))
    else $error("retrigger did not reload");
  a_clr_single_run_bit: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ16
    wr_clr && !soft_reset_bit && req_i.wdata[CB_SINGLE_RUN_BIT] |=> !single_run_bit)
    else $error("clear alias left single run on");
  a_clr_dir: assert property (@(posedge sys_clk_i) disable iff (!nrst_i) // RQ17
    wr_clr && !soft_reset_bit && req_i.wdata[CB_DIR] |=> !dir)
    else $error("clear alias left direction down");
endmodule
`default_nettype wire

// ---- sim/tcsr_top_tb.sv ----
// Purpose: self-checking bench for the timer control and sync registers
// Assumes: kernel tick every 4 system cycles, counter steps once per tick
// Notes: bus tasks leave the strobe up so calls run back to back
`timescale 1ns/1ps
`default_nettype none
module tcsr_top_tb import tcsr_pkg::*; ;
  logic sys_clk_i = 1'b0;
  logic nrst_i = 1'b0;
  tcsr_req_t req = '0;
  logic start_evt_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  logic [DATA_W-1:0] count_o;
  logic running_o;
  logic active_o;
  logic dir_o;
  logic one_shot_o;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [15:0] s1;
  logic [15:0] s2;

  tcsr_top u_tcsr_top (
    .sys_clk_i(sys_clk_i),
    .nrst_i(nrst_i),
    .req_i(req),
    .start_evt_i(start_evt_i),
    .rdata_o(rdata_o),
    .count_o(count_o),
    .running_o(running_o),
    .active_o(active_o),
    .dir_o(dir_o),
    .one_shot_o(one_shot_o)
  );

  // 10 MHz system clock
  always #50 sys_clk_i = ~sys_clk_i;

  // Cut a hang short
  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask

  // One bus cycle, taken at the next edge
  task automatic bus(input logic w, input logic [4:0] a, input logic [15:0] d);
    req.we <= w;
    req.re <= !w;
    req.addr <= a;
    req.wdata <= d;
    @(posedge sys_clk_i);
    #1;
  endtask

  task automatic idle(input int n);
    req.we <= 1'b0;
    req.re <= 1'b0;
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    bus(1'b0, a, 16'h0000);
    v = rdata_o;
  endtask

  task automatic rdc(input string n, input logic [4:0] a, input logic [15:0] e);
    logic [15:0] v;
    rd(a, v);
    chk(n, v, e);
  endtask

  // Poll a status bit until it drops, bounded
  task automatic wait_clear(input logic [4:0] a, input logic [15:0] m);
    logic [15:0] v;
    v = m;
    for (int i = 0; i < 20 && (v & m) !== 16'h0000; i++) begin
      rd(a, v);
    end
    chk("busy clear", v & m, 16'h0000);
  endtask

  task automatic wait_run(input logic v);
    for (int i = 0; i < 1000 && running_o !== v; i++) begin
      idle(1);
    end
    chk("running", {15'h0, running_o}, {15'h0, v});
  endtask

  // Counter change over exactly two ticks
  task automatic count_step(input logic [15:0] e);
    logic [15:0] c;
    c = count_o;
    idle(8);
    chk("count step", count_o - c, e);
  endtask

  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk_i);
    nrst_i <= 1'b1;
    idle(1);
    rdc("primary", OFS_PRIMARY, 16'h0000);
    rdc("read req", OFS_READ_REQ, 16'h0000);
    rdc("clr alias", OFS_CB_CLR, 16'h0000);
    rdc("set alias", OFS_CB_SET, 16'h0000);
    rdc("status", OFS_STATUS, 16'h0000);
    rdc("unmapped", 5'h1f, 16'h0000);
    // Enable: immediate readback, busy, later applied
    wr(OFS_PRIMARY, 16'h0002);
    chk("active early", {15'h0, active_o}, 16'h0000);
    rdc("enable busy", OFS_STATUS, 16'h0002);
    rdc("enable rb", OFS_PRIMARY, 16'h0002);
    wait_clear(OFS_STATUS, 16'h0002);
    idle(2);
    chk("active", {15'h0, active_o}, 16'h0001);
    count_step(16'h0002);
    wr(OFS_CC0, 16'h1234);
    rdc("cc0 live", OFS_CC0, 16'h1234);
    // Single and continuous read sync of the counter, then single read sync of compare 0
    wr(OFS_READ_REQ, 16'h8010);
    rdc("read busy", OFS_STATUS, 16'h0004);
    rdc("req reads 0", OFS_READ_REQ, 16'h0010);
    wait_clear(OFS_STATUS, 16'h0004);
    rd(OFS_COUNT, s1);
    idle(8);
    rd(OFS_COUNT, s2);
    chk("snapshot", s2, s1);
    wr(OFS_READ_REQ, 16'h4010);
    idle(8);
    rd(OFS_COUNT, s1);
    idle(8);
    rd(OFS_COUNT, s2);
    chk("resync", {15'h0, s2 !== s1}, 16'h0001);
    wr(OFS_READ_REQ, 16'h8018);
    wait_clear(OFS_STATUS, 16'h0004);
    rdc("cc0 sync", OFS_CC0, 16'h1234);
    // Aliases, direction and single run
    wr(OFS_CB_SET, 16'h0001);
    rdc("dir clr", OFS_CB_CLR, 16'h0001);
    rdc("dir set", OFS_CB_SET, 16'h0001);
    idle(2);
    chk("dir out", {15'h0, dir_o}, 16'h0001);
    count_step(16'hfffe);
    wr(OFS_CB_CLR, 16'h0000);
    rdc("clr zero", OFS_CB_SET, 16'h0001);
    wr(OFS_CB_SET, 16'h0004);
    rdc("one shot", OFS_CB_CLR, 16'h0005);
    idle(2);
    chk("one shot out", {15'h0, one_shot_o}, 16'h0001);
    wait_run(1'b0);
    idle(2);
    chk("wrap stop", count_o, 16'hffff);
    count_step(16'h0000);
    wr(OFS_CB_CLR, 16'h0004);
    rdc("one shot off", OFS_CB_SET, 16'h0001);
    // Retrigger, stop, start event
    wr(OFS_CB_SET, 16'h0040);
    wait_run(1'b1);
    rdc("cmd done", OFS_CB_SET, 16'h0001);
    count_step(16'hfffe);
    wr(OFS_CB_SET, 16'h0080);
    wait_run(1'b0);
    count_step(16'h0000);
    rdc("stop done", OFS_CB_CLR, 16'h0001);
    start_evt_i <= 1'b1;
    wait_run(1'b1);
    start_evt_i <= 1'b0;
    // Disable while running, commands stay pending
    wr(OFS_PRIMARY, 16'h0000);
    wait_clear(OFS_STATUS, 16'h0002);
    idle(2);
    chk("inactive", {15'h0, active_o}, 16'h0000);
    wr(OFS_CB_SET, 16'h0040);
    rdc("pending", OFS_CB_SET, 16'h0041);
    wr(OFS_CB_SET, 16'h0000);
    rdc("zero keeps", OFS_CB_CLR, 16'h0041);
    wr(OFS_CB_CLR, 16'h00c0);
    rdc("cancel", OFS_CB_SET, 16'h0001);
    wr(OFS_CB_SET, 16'h00c0);
    rdc("reserved", OFS_CB_CLR, 16'h00c1);
    wr(OFS_CB_CLR, 16'h00c0);
    rdc("cancel rsvd", OFS_CB_SET, 16'h0001);
    // Soft reset with enable in the same write
    wr(OFS_DEBUG, 16'h0001);
    // Land the reset write just after a kernel tick so two reads see it busy
    idle(2);
    wr(OFS_PRIMARY, 16'h0003);
    rdc("soft_reset_bit rb", OFS_PRIMARY, 16'h0001);
    rdc("soft_reset_bit busy", OFS_STATUS, 16'h0001);
    wait_clear(OFS_STATUS, 16'h0001);
    rdc("soft_reset_bit done", OFS_PRIMARY, 16'h0000);
    rdc("cb reset", OFS_CB_SET, 16'h0000);
    rdc("cc0 reset", OFS_CC0, 16'h0000);
    rdc("rr reset", OFS_READ_REQ, 16'h0000);
    rdc("debug kept", OFS_DEBUG, 16'h0001);
    // Direction set, then cleared through the clear alias
    wr(OFS_CB_SET, 16'h0001);
    rdc("dir again", OFS_CB_CLR, 16'h0001);
    wr(OFS_CB_CLR, 16'h0001);
    rdc("dir cleared", OFS_CB_SET, 16'h0000);
    idle(2);
    chk("reset off", {15'h0, active_o}, 16'h0000);
    end_of_test();
  end
endmodule
`default_nettype wire
